// >>> logic/pwm_top.v
// Functional notes
// - Status bit shows channel output enabled.
// - Interrupt enable write: ones set enables.
// - Interrupt disable write: ones clear enables.
// - Mask view shows enabled channel interrupts.
// - Flag set after full period since read.
// - Reading flags register clears all flags except those ending a period that cycle.
// - Clock select: powers of two, A, B.
// - Alignment bit: left or centre period.
// - Start level bit sets period start level.
// - Target bit routes staged value: duty/period.
// - Only low sixteen bits take effect.
// - Left period equals period times divider.
// - Centre period equals twice that product.
// - Counter cleared when channel is enabled.
// - Left mode counter wraps at period.
// - Staged value copied at next period start.
// - Output enable set/clear by written ones.
// - Zero divider factor stops divided clock.
//
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "pwm_regs.vh"

module pwm_top #(
   parameter CW = 16,
   parameter NCH = 4
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata_q,
   output wire [NCH-1:0] pwm_out
);

   // ****************************************
   // Helper functions
   // ****************************************

   // True when a prescaler code's tick falls in this cycle.
   // Code n ticks once every two to the n master clocks.
   function pre_tick;
      input [3:0] code;
      input [9:0] cnt;
      reg [9:0] mask;
      begin
         mask = (10'h001 << code) - 10'h001;
         if (code > `SEL_MAX_POWER) begin
            pre_tick = 1'b0;
         end else begin
            pre_tick = ((cnt & mask) == mask);
         end
      end
   endfunction

   // Channel clock from its selector code.
   // Reserved codes give no tick, so the counter holds.
   function chan_tick;
      input [3:0] code;
      input [9:0] cnt;
      input divided_clock_a;
      input divided_clock_b;
      begin
         if (code == `SEL_CLK_A) begin
            chan_tick = divided_clock_a;
         end else if (code == `SEL_CLK_B) begin
            chan_tick = divided_clock_b;
         end else begin
            chan_tick = pre_tick(code, cnt);
         end
      end
   endfunction

   // ****************************************
   // Bus front end
   // ****************************************

   // Captured address of the transfer now in data phase.
   reg [11:0] addr_q;
   // Write data phase in progress.
   reg wr_q;
   // Read data phase in progress (one wait state).
   reg rd_q;
   // Transfer accepted in this address phase.
   wire take = hsel & htrans[1] & hready;

   // Reads insert one wait so that the data reflects writes just done.
   assign hreadyout = ~rd_q;
   // Every transfer completes with an OKAY response.
   assign hresp = 1'b0;

   // Address phase capture.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_q <= 12'h000;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
      end else if (take) begin
         addr_q <= haddr[11:0];
         wr_q <= hwrite;
         rd_q <= ~hwrite;
      end else begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
      end
   end

   // Decoded write strobes, valid in the write data phase.
   wire w_gcfg = wr_q & (addr_q == `OFF_CLOCK_CONFIG);
   wire w_enset = wr_q & (addr_q == `OFF_OUT_EN_SET);
   wire w_enclr = wr_q & (addr_q == `OFF_OUT_EN_CLR);
   wire w_irqset = wr_q & (addr_q == `OFF_IRQ_EN_SET);
   wire w_irqclr = wr_q & (addr_q == `OFF_IRQ_EN_CLR);
   // Read of the flag register, used for its clearing side effect.
   wire r_flags = rd_q & (addr_q == `OFF_DONE_FLAGS);

   // Channel area: 32-byte window per channel.
   wire ch_area = (addr_q[11:9] == `CH_AREA_BASE) & (addr_q[8:7] == 2'b00);
   // Channel selected by the captured address.
   wire [1:0] ch_idx = addr_q[6:5];
   // Register selected inside the channel window.
   wire [4:0] ch_reg = addr_q[4:0];

   // ****************************************
   // Global state
   // ****************************************

   // Divider factors and prescaler codes for A and B.
   reg [31:0] gcfg_q;
   // Channel outputs enabled.
   reg [NCH-1:0] en_q;
   // Channel interrupts enabled.
   reg [NCH-1:0] irq_en_q;
   // Period completed since the last flag read.
   reg [NCH-1:0] flag_q;
   // Free master clock prescaler.
   reg [9:0] presc_q;
   // Period end pulses from the channels.
   wire [NCH-1:0] pend;
   // Divided clock ticks.
   wire divided_clock_a_tick;
   wire divided_clock_b_tick;

   // Master clock prescaler shared by all users.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         presc_q <= 10'h000;
      end else begin
         presc_q <= presc_q + 10'h001;
      end
   end

   // Global clock configuration register.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gcfg_q <= `RST_CLOCK_CONFIG;
      end else if (w_gcfg) begin
         gcfg_q <= hwdata & 32'h0FFF_0FFF;
      end
   end

   // Output enables: ones written set or clear, zeros leave alone.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         en_q <= {NCH{1'b0}};
      end else begin
         if (w_enset) begin
            en_q <= en_q | hwdata[NCH-1:0];
         end else if (w_enclr) begin
            en_q <= en_q & ~hwdata[NCH-1:0];
         end
      end
   end

   // Interrupt enables: the same set and clear scheme.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_en_q <= {NCH{1'b0}};
      end else begin
         if (w_irqset) begin
            irq_en_q <= irq_en_q | hwdata[NCH-1:0];
         end else if (w_irqclr) begin
            irq_en_q <= irq_en_q & ~hwdata[NCH-1:0];
         end
      end
   end

   // Period flags: a period end in the clearing cycle still sets the flag.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flag_q <= {NCH{1'b0}};
      end else if (r_flags) begin
         flag_q <= pend;
      end else begin
         flag_q <= flag_q | pend;
      end
   end

   // ****************************************
   // Divided clocks A and B
   // ****************************************

   clock_divider u_div_a (
      .hclk(hclk),
      .hresetn(hresetn),
      .pre_tick(pre_tick(gcfg_q[`F_PREA_LO+3:`F_PREA_LO], presc_q)),
      .factor(gcfg_q[`F_DIVIDER_FACTOR_A_LO+7:`F_DIVIDER_FACTOR_A_LO]),
      .tick_q(divided_clock_a_tick)
   );

   clock_divider u_div_b (
      .hclk(hclk),
      .hresetn(hresetn),
      .pre_tick(pre_tick(gcfg_q[`F_PREB_LO+3:`F_PREB_LO], presc_q)),
      .factor(gcfg_q[`F_DIVIDER_FACTOR_B_LO+7:`F_DIVIDER_FACTOR_B_LO]),
      .tick_q(divided_clock_b_tick)
   );

   // ****************************************
   // Channels
   // ****************************************

   // Per-channel configuration: selector, alignment, level, target.
   reg [10:0] ccfg_q [0:NCH-1];
   // Read views of channel duty, period and count.
   wire [CW-1:0] duty_v [0:NCH-1];
   wire [CW-1:0] period_v [0:NCH-1];
   wire [CW-1:0] count_v [0:NCH-1];

   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : gch
         // This channel is addressed.
         wire hit = wr_q & ch_area & (ch_idx == g);
         // Selected counter clock for this channel.
         wire tick = chan_tick(ccfg_q[g][3:0], presc_q, divided_clock_a_tick, divided_clock_b_tick);

         // Channel configuration register.
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               ccfg_q[g] <= `RST_CH_CONFIG;
            end else if (hit & (ch_reg == `OFF_CH_CONFIG)) begin
               ccfg_q[g] <= {hwdata[10:8], 4'h0, hwdata[3:0]};
            end
         end

         pwm_channel #(
            .CW(CW)
         ) u_ch (
            .hclk(hclk),
            .hresetn(hresetn),
            .tick(tick),
            .run(en_q[g]),
            .restart(w_enset & hwdata[g]),
            .align(ccfg_q[g][`F_ALIGN]),
            .start_high(ccfg_q[g][`F_START]),
            .target(ccfg_q[g][`F_TARGET]),
            .duty_we(hit & (ch_reg == `OFF_CH_DUTY)),
            .period_we(hit & (ch_reg == `OFF_CH_PERIOD)),
            .stage_we(hit & (ch_reg == `OFF_CH_STAGED)),
            .wdata(hwdata[CW-1:0]),
            .duty_q(duty_v[g]),
            .period_q(period_v[g]),
            .count_q(count_v[g]),
            .wave_q(pwm_out[g]),
            .period_end(pend[g])
         );
      end
   endgenerate

   // ****************************************
   // Read path
   // ****************************************

   // Read mux: unmapped and write-only locations read as zero.
   reg [31:0] rmux;
   // Channel index used by the mux.
   reg [1:0] ci;

   // Decoding is an if chain; channel registers zero-extend to 32 bits.
   always @* begin
      rmux = 32'h0000_0000;
      ci = ch_idx;
      if (addr_q == `OFF_CLOCK_CONFIG) begin
         rmux = gcfg_q;
      end else if (addr_q == `OFF_EN_STATE) begin
         rmux[NCH-1:0] = en_q;
      end else if (addr_q == `OFF_IRQ_VIEW) begin
         rmux[NCH-1:0] = irq_en_q;
      end else if (addr_q == `OFF_DONE_FLAGS) begin
         rmux[NCH-1:0] = flag_q;
      end else if (ch_area & (ch_reg == `OFF_CH_CONFIG)) begin
         rmux[10:0] = ccfg_q[ci];
      end else if (ch_area & (ch_reg == `OFF_CH_DUTY)) begin
         rmux[CW-1:0] = duty_v[ci];
      end else if (ch_area & (ch_reg == `OFF_CH_PERIOD)) begin
         rmux[CW-1:0] = period_v[ci];
      end else if (ch_area & (ch_reg == `OFF_CH_COUNT)) begin
         rmux[CW-1:0] = count_v[ci];
      end
   end

   // Read data is loaded at the end of the wait state and then stands.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h0000_0000;
      end else if (rd_q) begin
         hrdata_q <= rmux;
      end
   end

endmodule // pwm_top

// >>> common/pwm_regs.vh
`ifndef PWM_REGS_VH
`define PWM_REGS_VH
// ****************************************
// Global register byte offsets
// ****************************************
`define OFF_CLOCK_CONFIG 12'h000
`define OFF_OUT_EN_SET 12'h004
`define OFF_OUT_EN_CLR 12'h008
`define OFF_EN_STATE 12'h00C
`define OFF_IRQ_EN_SET 12'h010
`define OFF_IRQ_EN_CLR 12'h014
`define OFF_IRQ_VIEW 12'h018
`define OFF_DONE_FLAGS 12'h01C
// ****************************************
// Channel area: base plus stride per channel
// ****************************************
`define CH_AREA_BASE 3'b001
`define OFF_CH_CONFIG 5'h00
`define OFF_CH_DUTY 5'h04
`define OFF_CH_PERIOD 5'h08
`define OFF_CH_COUNT 5'h0C
`define OFF_CH_STAGED 5'h10
// ****************************************
// Field positions
// ****************************************
`define F_DIVIDER_FACTOR_A_LO 0
`define F_PREA_LO 8
`define F_DIVIDER_FACTOR_B_LO 16
`define F_PREB_LO 24
`define F_CLK_SEL_LO 0
`define F_ALIGN 8
`define F_START 9
`define F_TARGET 10
// ****************************************
// Reset values and selector codes
// ****************************************
`define RST_CLOCK_CONFIG 32'h0000_0000
`define RST_CH_CONFIG 11'h000
`define RST_CH_VALUE 16'h0000
`define SEL_MAX_POWER 4'h0A
`define SEL_CLK_A 4'h0B
`define SEL_CLK_B 4'h0C
`endif

// >>> logic/clock_divider.v
`timescale 1ns/1ps
// Divides a prescaled tick stream by an 8-bit factor.
module clock_divider (
   input wire hclk,
   input wire hresetn,
   input wire pre_tick,
   input wire [7:0] factor,
   output reg tick_q
);
   // Ticks of the selected prescaler seen so far.
   reg [7:0] cnt_q;

   // A factor of zero stops the clock; a factor of one passes every tick.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= 8'h00;
         tick_q <= 1'b0;
      end else if (factor == 8'h00) begin
         cnt_q <= 8'h00;
         tick_q <= 1'b0;
      end else if (pre_tick) begin
         if (cnt_q >= factor - 8'h01) begin
            cnt_q <= 8'h00;
            tick_q <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 8'h01;
            tick_q <= 1'b0;
         end
      end else begin
         tick_q <= 1'b0;
      end
   end
endmodule // clock_divider

// >>> logic/pwm_channel.v
`timescale 1ns/1ps
// One waveform channel: counter, double buffer and output stage.
module pwm_channel #(
   parameter CW = 16
) (
   input wire hclk,
   input wire hresetn,
   input wire tick,
   input wire run,
   input wire restart,
   input wire align,
   input wire start_high,
   input wire target,
   input wire duty_we,
   input wire period_we,
   input wire stage_we,
   input wire [CW-1:0] wdata,
   output reg [CW-1:0] duty_q,
   output reg [CW-1:0] period_q,
   output reg [CW-1:0] count_q,
   output reg wave_q,
   output wire period_end
);
   // Counting down in centre mode.
   reg down_q;
   // A staged value is waiting for the next period start.
   reg pend_q;
   // The staged value itself.
   reg [CW-1:0] stage_q;
   // Left mode wraps one tick before the period value, giving period ticks.
   wire left_wrap = (count_q + 1'b1 >= period_q) | (period_q == 0);
   // Centre mode ends one sweep when the down count comes back to zero.
   wire ctr_wrap = (period_q == 0) | (down_q & (count_q <= 1));
   assign period_end = run & tick & (align ? ctr_wrap : left_wrap);

   // Counter, direction, staging and the period start update.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_q <= {CW{1'b0}};
         down_q <= 1'b0;
         pend_q <= 1'b0;
         stage_q <= {CW{1'b0}};
         duty_q <= {CW{1'b0}};
         period_q <= {CW{1'b0}};
      end else begin
         if (restart) begin
            count_q <= {CW{1'b0}};
            down_q <= 1'b0;
         end else if (period_end) begin
            count_q <= {CW{1'b0}};
            down_q <= 1'b0;
            if (pend_q) begin
               pend_q <= 1'b0;
               if (target) begin
                  period_q <= stage_q;
               end else begin
                  duty_q <= stage_q;
               end
            end
         end else if (run & tick) begin
            if (!align) begin
               count_q <= count_q + 1'b1;
            end else if (down_q) begin
               count_q <= count_q - 1'b1;
            end else if (count_q >= period_q) begin
               down_q <= 1'b1;
               count_q <= count_q - 1'b1;
            end else begin
               count_q <= count_q + 1'b1;
            end
         end
         // A new staged write replaces any older one still waiting.
         if (stage_we) begin
            stage_q <= wdata;
            pend_q <= 1'b1;
         end
         if (duty_we) begin
            duty_q <= wdata;
         end
         if (period_we) begin
            period_q <= wdata;
         end
      end
   end

   // Start level while the count is below duty, otherwise the opposite level.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wave_q <= 1'b0;
      end else if (!run) begin
         wave_q <= 1'b0;
      end else begin
         wave_q <= (count_q < duty_q) ? start_high : ~start_high;
      end
   end
endmodule // pwm_channel

// >>> sim/pwm_top_monitor.sv
`timescale 1ns/1ps
// ****************************************
// Bus and register checker
// ****************************************
module pwm_top_monitor #(
   parameter CW = 16,
   parameter NCH = 4
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   input wire hreadyout,
   input wire hresp,
   input wire [31:0] hrdata_q,
   input wire [NCH-1:0] pwm_out
);
   // A transfer is taken at an edge with select, NONSEQ or SEQ, and ready.
   wire take = hsel & htrans[1] & hready;
   wire rd_take = take & ~hwrite;
   reg wr_q; // Write data phase in progress.
   reg [11:0] wa_q; // Address of that write.
   reg [NCH-1:0] en_q; // Shadow of the output enables.
   reg [NCH-1:0] ie_q; // Shadow of the interrupt enables.

   // Shadow state follows the set and clear writes, so reads can be judged.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         wa_q <= 12'h000;
         en_q <= {NCH{1'b0}};
         ie_q <= {NCH{1'b0}};
      end else begin
         wr_q <= take & hwrite;
         wa_q <= haddr[11:0];
         if (wr_q && wa_q == 12'h004) en_q <= en_q | hwdata[NCH-1:0];
         if (wr_q && wa_q == 12'h008) en_q <= en_q & ~hwdata[NCH-1:0];
         if (wr_q && wa_q == 12'h010) ie_q <= ie_q | hwdata[NCH-1:0];
         if (wr_q && wa_q == 12'h014) ie_q <= ie_q & ~hwdata[NCH-1:0];
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   resp_okay_a: assert property (hresp == 1'b0) else $error("response not OKAY");
   read_wait_a: assert property (rd_take |=> !hreadyout ##1 hreadyout) else $error("read wait not one cycle");
   write_nowait_a: assert property (take && hwrite |=> hreadyout) else $error("write was stalled");
   wait_cause_a: assert property ($fell(hreadyout) |-> $past(rd_take)) else $error("stall without a read");
   data_hold_a: assert property (!$past(rd_take, 2) |-> $stable(hrdata_q)) else $error("read data moved");
   state_read_a: assert property (rd_take && haddr[11:0] == 12'h00C |-> ##2 hrdata_q == {{(32-NCH){1'b0}}, en_q})
      else $error("enabled state read wrong");
   mask_read_a: assert property (rd_take && haddr[11:0] == 12'h018 |-> ##2 hrdata_q == {{(32-NCH){1'b0}}, ie_q})
      else $error("interrupt view read wrong");
   unmapped_zero_a: assert property (rd_take && haddr[11:0] == 12'h0FC |-> ##2 hrdata_q == 32'h0000_0000)
      else $error("unmapped read not zero");
   // The output lags the enable by one edge, so older enables are allowed for.
   off_idle_a: assert property ((pwm_out & ~(en_q | $past(en_q) | $past(en_q, 2) | $past(en_q, 3))) == 0)
      else $error("disabled channel output active");
endmodule // pwm_top_monitor

bind pwm_top pwm_top_monitor #(.CW(CW), .NCH(NCH)) mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .hrdata_q(hrdata_q), .pwm_out(pwm_out));

// >>> sim/pwm_top_tb.sv
`timescale 1ns/1ps
module pwm_top_tb;
   // ****************************************
   // Stimulus signals and design
   // ****************************************
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010;
   wire hreadyout;
   wire hresp;
   wire [31:0] hrdata_q;
   wire [3:0] pwm_out;
   integer failures = 0;
   integer compares = 0;
   integer i, j, hi, lo;
   logic [31:0] v;
   // Waveform table: config, period, duty, high cycles (-1 unchecked), full period.
   logic [31:0] t_cfg [0:5] = '{32'h0000_0000, 32'h0000_0200, 32'h0000_0001, 32'h0000_0100, 32'h0000_000B,
      32'h0000_000A};
   integer t_p [0:5] = '{10, 10, 10, 5, 4, 2};
   integer t_d [0:5] = '{4, 4, 4, 2, 1, 1};
   integer t_hi [0:5] = '{6, 4, 12, -1, 9, 1024};
   integer t_per [0:5] = '{10, 10, 20, 10, 12, 2048};

   always #50 hclk = ~hclk;

   pwm_top #(.CW(16), .NCH(4)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata_q(hrdata_q), .pwm_out(pwm_out));

   // ****************************************
   // Bus tasks and comparisons
   // ****************************************
   task close_out;
      begin
         if (failures == 0 && compares > 0) begin
            $display("TB: PASS");
         end else begin
            $display("TB: FAIL");
         end
         $finish;
      end
   endtask

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         end
      end
   endtask

   // Bounded wait, so a slave that never answers is reported, not hung on.
   task wait_ready;
      integer n;
      begin
         n = 0;
         do begin
            @(posedge hclk);
            n = n + 1;
         end while (hreadyout !== 1'b1 && n < 20);
         if (n >= 20) chk("hready", 32'h0000_0001, {31'h0, hreadyout});
      end
   endtask

   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      begin
         hsel <= 1'b1;
         htrans <= 2'b10;
         haddr <= a;
         hwrite <= w;
         wait_ready;
         htrans <= 2'b00;
         hsel <= 1'b0;
         hwdata <= d;
         wait_ready;
         r = hrdata_q;
      end
   endtask

   task wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      begin
         xfer(1'b1, a, d, r);
      end
   endtask

   task rdc(input string what, input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] r;
      begin
         xfer(1'b0, a, 32'h0000_0000, r);
         chk(what, exp, r);
      end
   endtask

   function logic [31:0] ch(input integer n, input integer off);
      ch = 32'h0000_0200 + 32 * n + off;
   endfunction

   // Waits for the output of channel c to go from low to high.
   task rise(input integer c);
      begin
         while (pwm_out[c] !== 1'b0) @(posedge hclk);
         while (pwm_out[c] !== 1'b1) @(posedge hclk);
      end
   endtask

   task meas(input integer c, output integer h, output integer l);
      begin
         h = 0;
         l = 0;
         rise(c);
         while (pwm_out[c] === 1'b1) begin
            @(posedge hclk);
            h = h + 1;
         end
         while (pwm_out[c] === 1'b0) begin
            @(posedge hclk);
            l = l + 1;
         end
      end
   endtask

   // Watchdog: the whole sequence needs about 5000 cycles.
   initial begin
      repeat (40000) @(posedge hclk);
      failures = failures + 1;
      close_out;
   end

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (i = 0; i < 16; i = i + 4) rdc("global_reset", 32'h0000_000C + i, 32'h0000_0000);
      for (i = 0; i < 4; i = i + 1) begin
         for (j = 0; j < 16; j = j + 4) rdc("chan_reset", ch(i, j), 32'h0000_0000);
      end
      wr(32'h0000_0000, 32'hFFFF_FFFF);
      rdc("clock_config", 32'h0000_0000, 32'h0FFF_0FFF);
      wr(ch(1, 0), 32'hFFFF_FFFF);
      rdc("chan_config", ch(1, 0), 32'h0000_070F);
      wr(ch(1, 4), 32'hABCD_1234);
      rdc("duty_low16", ch(1, 4), 32'h0000_1234);
      wr(ch(1, 8), 32'h5678_9ABC);
      rdc("period_low16", ch(1, 8), 32'h0000_9ABC);
      wr(32'h0000_00FC, 32'h0000_1234);
      rdc("unmapped", 32'h0000_00FC, 32'h0000_0000);
      // Zero bits must leave enables alone, so the interrupt enable writes and the first output enable clear mix ones and zeros.
      wr(32'h0000_0010, 32'h0000_0005);
      rdc("irq_view", 32'h0000_0018, 32'h0000_0005);
      wr(32'h0000_0010, 32'h0000_0002);
      rdc("irq_view", 32'h0000_0018, 32'h0000_0007);
      wr(32'h0000_0014, 32'h0000_0001);
      rdc("irq_view", 32'h0000_0018, 32'h0000_0006);
      wr(32'h0000_0004, 32'h0000_000F);
      rdc("en_state", 32'h0000_000C, 32'h0000_000F);
      wr(32'h0000_0008, 32'h0000_0005);
      rdc("en_state", 32'h0000_000C, 32'h0000_000A);
      wr(32'h0000_0008, 32'h0000_000F);
      // Divided clock A: prescaler 1, factor 3.
      wr(32'h0000_0000, 32'h0000_0003);
      for (i = 0; i < 6; i = i + 1) begin
         j = i % 4;
         wr(32'h0000_0008, 32'h0000_0001 << j);
         wr(ch(j, 0), t_cfg[i]);
         wr(ch(j, 4), t_d[i]);
         wr(ch(j, 8), t_p[i]);
         wr(32'h0000_0004, 32'h0000_0001 << j);
         meas(j, hi, lo);
         chk("wave_period", t_per[i], hi + lo);
         if (t_hi[i] >= 0) chk("wave_high", t_hi[i], hi);
      end
      // Flags: nothing runs, so a second read must find them clear.
      wr(32'h0000_0008, 32'h0000_000F);
      rdc("flags_any", 32'h0000_001C, 32'h0000_000F);
      rdc("flags_clear", 32'h0000_001C, 32'h0000_0000);
      wr(32'h0000_0004, 32'h0000_0008);
      repeat (30) @(posedge hclk);
      rdc("flags_set", 32'h0000_001C, 32'h0000_0008);
      wr(32'h0000_0008, 32'h0000_0008);
      wr(32'h0000_0008, 32'h0000_0008);
      rdc("flags_clear", 32'h0000_001C, 32'h0000_0000);
      // Stopped clock A and a reserved code must both hold the counter.
      wr(32'h0000_0000, 32'h0000_0000);
      wr(ch(0, 0), 32'h0000_000B);
      wr(ch(1, 0), 32'h0000_000D);
      wr(32'h0000_0004, 32'h0000_0003);
      repeat (30) @(posedge hclk);
      rdc("count_stop_a", ch(0, 12), 32'h0000_0000);
      rdc("count_reserved", ch(1, 12), 32'h0000_0000);
      // Re-enabling a running channel clears its counter.
      wr(ch(2, 0), 32'h0000_0000);
      wr(ch(2, 8), 32'h0000_03E8);
      wr(32'h0000_0004, 32'h0000_0004);
      repeat (100) @(posedge hclk);
      wr(32'h0000_0004, 32'h0000_0004);
      xfer(1'b0, ch(2, 12), 32'h0000_0000, v);
      chk("count_cleared", 32'h0000_0001, {31'h0, v < 32'd8});
      // Staged values wait for the next period; prescaler 16 leaves room for the bus.
      wr(32'h0000_0008, 32'h0000_0001);
      wr(ch(0, 0), 32'h0000_0004);
      wr(ch(0, 4), 32'h0000_0004);
      wr(ch(0, 8), 32'h0000_000A);
      wr(32'h0000_0004, 32'h0000_0001);
      rise(0);
      wr(ch(0, 16), 32'h0000_0008);
      rdc("duty_held", ch(0, 4), 32'h0000_0004);
      meas(0, hi, lo);
      chk("staged_duty_high", 32'd32, hi);
      rdc("duty_updated", ch(0, 4), 32'h0000_0008);
      rise(0);
      wr(ch(0, 0), 32'h0000_0404);
      wr(ch(0, 16), 32'h0001_0014);
      rdc("period_held", ch(0, 8), 32'h0000_000A);
      meas(0, hi, lo);
      chk("staged_period", 32'd320, hi + lo);
      rdc("period_updated", ch(0, 8), 32'h0000_0014);
      close_out;
   end
endmodule // pwm_top_tb
